/* rtl/sadcp_port.sv */
// Purpose: serial port and conversion sequencer of a 12-bit sampling adc
// Assumes: link pins are asynchronous; shift clock far slower than mclk
// Notes: the comparator answer is taken from the analog core each step
//
// Notes on behaviour
// - launch on falling edge, sample on rising
// - skip zeros, first one starts; then ignore
// - word is mode, channel/polarity, bit order
// - null bit, then result; select high resets
// - order bit one: msb first, then zeros
// - order bit zero: msb first, then lsb first
// - result is unipolar straight binary
// - drive line low on 4th fall
// - active only while select low
// - clock and data ignored while select high
// - core powers down after each conversion
// - power-down never waits for select rising
// - window opens before order bit, closes after
// - fall after order bit: hold and convert
`timescale 1ns/1ps
module sadcp_port
  import sadcp_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // serial link pins
  input wire logic select_shutdown_n,
  input wire logic sclk,
  input wire logic sdi,
  output logic sdo,
  output logic sdo_oe,
  // analog core control
  output logic core_power,
  output logic sample_window,
  output logic hold,
  output logic input_mode_bit,
  output logic chan_odd,
  output logic [RES_W-1:0] dac_code,
  input wire logic comp_high,
  // result stream
  output logic res_valid,
  input wire logic res_ready,
  output logic [FIFO_W-1:0] res_data
);
  logic [2:0] pins; // synchronised {select, clock, data}
  logic [2:0] pin_rise; // rising edges seen
  logic [2:0] pin_fall; // falling edges seen
  logic cs_hi; // select high: port held in reset
  logic sclk_rise; // host has launched, sample now
  logic sclk_fall; // launch our next bit
  logic din; // synchronised serial input
  sadcp_state_e state; // sequence position
  sadcp_state_e next_state;
  logic [CNT_W-1:0] cnt; // bit counter within a phase
  logic [CNT_W-1:0] next_cnt;
  logic [2:0] cfg; // {mode, odd, order} once complete
  logic [2:0] next_cfg;
  logic [RES_W-1:0] result; // decided bits so far
  logic [RES_W-1:0] next_result;
  logic [RES_W-1:0] trial; // one-hot bit under test
  logic [RES_W-1:0] next_trial;
  logic next_sdo;
  logic next_sdo_oe;
  logic next_window;
  logic next_hold;
  logic next_power;
  logic push; // result word to the buffer
  logic next_push;
  logic [FIFO_W-1:0] push_data;
  logic [FIFO_W-1:0] next_push_data;
  logic fifo_ready; // room for one more result
  logic [5:0] falls; // falls since start bit, checked below
  logic [5:0] next_falls;
  logic [RES_W-1:0] next_dac_code; // decided bits plus the bit under test
  logic [1:0] mux_sel; // {mode, odd} latched as each bit lands
  logic [1:0] next_mux_sel;

  // pins pass two flops before anything reads them
  sadcp_sync #(.W(3)) u_sync (
    .mclk(mclk),
    .rst(rst),
    .async_in({select_shutdown_n, sclk, sdi}),
    .sync_out(pins),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign cs_hi = pins[2];
  assign sclk_rise = pin_rise[1];
  assign sclk_fall = pin_fall[1];
  assign din = pins[0];

  // mux address taken bit by bit, so the channel is steered while sampling;
  // the shift register alone only lines up after the order bit
  assign input_mode_bit = mux_sel[1];
  assign chan_odd = mux_sel[0];
  assign next_dac_code = next_result | next_trial;

  // sequencer next state
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_cfg = cfg;
    next_mux_sel = mux_sel;
    next_result = result;
    next_trial = trial;
    next_sdo = sdo;
    next_sdo_oe = sdo_oe;
    next_window = sample_window;
    next_hold = hold;
    next_power = core_power;
    next_push = 1'b0;
    next_push_data = push_data;
    if (cs_hi) begin
      // select high: everything parked, pins ignored
      next_state = ST_IDLE;
      next_cnt = '0;
      next_sdo = 1'b0;
      next_sdo_oe = 1'b0;
      next_window = 1'b0;
      next_hold = 1'b0;
      next_power = 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          // leading zeros are skipped; a start bit is ignored while the buffer is full
          if (sclk_rise && din && fifo_ready) begin
            next_state = ST_CFG;
            next_cnt = '0;
            next_power = 1'b1;
          end
        end
        ST_CFG: begin
          if (sclk_rise) begin
            next_cfg = {cfg[1:0], din};
            // mode bit first, then channel/polarity bit
            if (cnt == '0) begin
              next_mux_sel[1] = din;
            end
            if (cnt == WIN_OPEN) begin
              next_mux_sel[0] = din;
            end
            next_cnt = cnt + 1'b1;
            if (cnt == CFG_LAST) begin
              next_state = ST_ARM;
            end
          end
          // odd bit is launched on this fall: start sampling
          if (sclk_fall && cnt == WIN_OPEN) begin
            next_window = 1'b1;
          end
        end
        ST_ARM: begin
          // the fall after the order bit: hold, drive, null bit
          if (sclk_fall) begin
            next_state = ST_CONV;
            next_window = 1'b0;
            next_hold = 1'b1;
            next_sdo_oe = 1'b1;
            next_sdo = 1'b0;
            next_cnt = '0;
            next_result = RES_RST;
            next_trial = TRIAL_INIT;
          end
        end
        ST_CONV: begin
          // one decision per fall, shown on the line at once
          if (sclk_fall) begin
            next_sdo = comp_high;
            next_result = comp_high ? (result | trial) : result;
            next_trial = trial >> 1;
            next_cnt = cnt + 1'b1;
            if (cnt == CONV_LAST) begin
              // core off now; the shifter keeps going on its own
              next_power = 1'b0;
              next_hold = 1'b0;
              next_push = 1'b1;
              next_push_data = {cfg[2:1], next_result};
              next_cnt = LSB_START;
              next_state = cfg[0] ? ST_ZERO : ST_LSB;
            end
          end
        end
        ST_LSB: begin
          // b0 already out; repeat b1 up to b11
          if (sclk_fall) begin
            next_sdo = result[cnt];
            next_cnt = cnt + 1'b1;
            if (cnt == CONV_LAST) begin
              next_state = ST_ZERO;
            end
          end
        end
        ST_ZERO: begin
          // zeros for as long as the host keeps clocking
          if (sclk_fall) begin
            next_sdo = 1'b0;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      cnt <= '0;
      cfg <= CFG_RST;
      mux_sel <= CFG_RST[2:1];
      result <= RES_RST;
      trial <= RES_RST;
      dac_code <= RES_RST;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      sample_window <= 1'b0;
      hold <= 1'b0;
      core_power <= 1'b0;
      push <= 1'b0;
      push_data <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      cfg <= next_cfg;
      mux_sel <= next_mux_sel;
      result <= next_result;
      trial <= next_trial;
      dac_code <= next_dac_code;
      sdo <= next_sdo;
      sdo_oe <= next_sdo_oe;
      sample_window <= next_window;
      hold <= next_hold;
      core_power <= next_power;
      push <= next_push;
      push_data <= next_push_data;
    end
  end

  // results wait here until the user side drains them;
  // one word per frame, and a frame starts only with room left
  sadcp_fifo #(.W(FIFO_W), .DEPTH(DEPTH)) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(push_data),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );

  // helper: falls counted from the start bit, saturating so it never wraps
  always_comb begin
    next_falls = falls;
    if (next_state == ST_IDLE) begin
      next_falls = FALL_RST;
    end else if (sclk_fall && falls != 6'h3f) begin
      next_falls = falls + 1'b1;
    end
  end

  // helper register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      falls <= FALL_RST;
    end else begin
      falls <= next_falls;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  sequence s_start;
    state == ST_IDLE && !cs_hi && sclk_rise && din && fifo_ready;
  endsequence

  sequence s_order_taken;
    state == ST_CFG && sclk_rise && cnt == CFG_LAST;
  endsequence

  a_line_free: assert property (cs_hi |=> !sdo_oe)
    else $error("serial output driven while select high");
  a_cs_reset: assert property (cs_hi |=> state == ST_IDLE && !core_power)
    else $error("port not parked while select high");
  a_start_power: assert property (s_start |=> state == ST_CFG && core_power)
    else $error("start bit not taken");
  a_drive_fourth: assert property ($rose(sdo_oe) |-> falls == DRIVE_FALL && !sdo)
    else $error("line not driven low on fourth fall");
  a_cfg_frozen: assert property (state inside {ST_CONV, ST_LSB, ST_ZERO} && !cs_hi
    |=> $stable(cfg))
    else $error("input taken after configuration word");
  a_window_span: assert property (s_order_taken ##1 (!sclk_fall)[*1] |-> sample_window)
    else $error("sample window closed too early");
  a_hold_on_fall: assert property ($fell(sample_window) && !cs_hi |-> hold && $past(sclk_fall))
    else $error("hold not entered on fall after order bit");
  a_core_off: assert property (state inside {ST_LSB, ST_ZERO} |-> !core_power)
    else $error("core still powered after conversion");
  a_zero_fill: assert property (state == ST_ZERO && !cs_hi && sclk_fall |=> !sdo)
    else $error("nonzero bit in zero fill");
  a_lsb_copy: assert property (state == ST_LSB && !cs_hi && sclk_fall
    |=> sdo == $past(result[cnt]))
    else $error("reversed copy bit wrong");
  a_launch_fall: assert property ($changed(sdo) && !cs_hi && $past(!cs_hi) |-> $past(sclk_fall))
    else $error("output changed away from a falling edge");
  a_push_code: assert property (push |-> push_data[RES_W-1:0] == result)
    else $error("pushed code differs from shifted result");
  a_mux_early: assert property (state == ST_CFG && cnt == CFG_LAST |-> {input_mode_bit, chan_odd} == cfg[1:0])
    else $error("mux address not steered during sampling");
endmodule // sadcp_port

/* rtl/sadcp_pkg.sv */
// Purpose: shared constants for the serial adc port sequencer
// Assumes: 12-bit result, 3-bit configuration word after the start bit
// Notes: counts are in shift-clock edges, not mclk cycles
package sadcp_pkg;
  localparam int RES_W = 12; // result width
  localparam int CNT_W = 4; // edge counter width
  localparam int FIFO_DEPTH = 32; // result words buffered
  localparam int FIFO_W = RES_W + 2; // {mode, odd, result}
  localparam int DRIVE_FALL = 4; // falls after start bit until line driven
  localparam logic [CNT_W-1:0] CFG_LAST = 4'h2; // count when bit-order bit arrives
  localparam logic [CNT_W-1:0] WIN_OPEN = 4'h1; // count when window opens
  localparam logic [CNT_W-1:0] CONV_LAST = 4'hb; // last conversion step
  localparam logic [CNT_W-1:0] LSB_START = 4'h1; // first bit of the reversed copy
  localparam logic [RES_W-1:0] TRIAL_INIT = 12'h800; // first trial bit (msb)
  localparam logic [RES_W-1:0] RES_RST = 12'h000; // result after reset
  localparam logic [2:0] CFG_RST = 3'h0; // configuration after reset
  localparam logic [5:0] FALL_RST = 6'h00; // helper count after reset

  // port sequence states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, // looking for the start bit
    ST_CFG = 3'b001, // shifting in the configuration word
    ST_ARM = 3'b010, // waiting for the fall that starts conversion
    ST_CONV = 3'b011, // null bit and successive approximation
    ST_LSB = 3'b100, // reversed copy of the result
    ST_ZERO = 3'b101 // zero fill until select rises
  } sadcp_state_e;
endpackage

/* rtl/sadcp_sync.sv */
// Purpose: two-flop synchroniser with edge detect for link pins
// Assumes: inputs are asynchronous to mclk
// Notes: edges are seen one to two mclk cycles after the pin moves
`timescale 1ns/1ps
module sadcp_sync #(
  parameter int W = 3
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // pins and synchronised view
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  logic [W-1:0] meta; // first stage, read only by the second
  logic [W-1:0] prev; // delayed copy for edge detect

  // two stages plus one history flop
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      meta <= '1;
      sync_out <= '1;
      prev <= '1;
    end else begin
      meta <= async_in;
      sync_out <= meta;
      prev <= sync_out;
    end
  end

  assign rise = sync_out & ~prev;
  assign fall = ~sync_out & prev;
endmodule // sadcp_sync

/* rtl/sadcp_fifo.sv */
// Purpose: result buffer between the port and the user stream
// Assumes: depth is a power of two
// Notes: in_ready low means full, out_valid low means empty
`timescale 1ns/1ps
module sadcp_fifo #(
  parameter int W = 14,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH]; // storage flops
  logic [AW-1:0] wp; // write index
  logic [AW-1:0] rp; // read index
  logic [AW:0] cnt; // words held
  logic [AW-1:0] next_wp;
  logic [AW-1:0] next_rp;
  logic [AW:0] next_cnt;
  logic wr; // accepted write
  logic rd; // accepted read

  assign in_ready = (cnt != DEPTH[AW:0]);
  assign out_valid = (cnt != '0);
  assign out_data = mem[rp];
  assign wr = in_valid & in_ready;
  assign rd = out_valid & out_ready;

  // pointer and count update
  always_comb begin
    next_wp = wr ? wp + 1'b1 : wp;
    next_rp = rd ? rp + 1'b1 : rp;
    next_cnt = cnt + {{AW{1'b0}}, wr} - {{AW{1'b0}}, rd};
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge mclk) begin
    if (wr) begin
      mem[wp] <= in_data;
    end
  end
endmodule // sadcp_fifo

/* dv/sadcp_host.sv */
// Purpose: host model for the serial link of the adc port
// Assumes: one shared data wire, shift clock built from mclk
// Notes: each shift clock level lasts HALF mclk cycles; clock stands still between frames except while noise chatters it
`timescale 1ns/1ps
module sadcp_host #(
  // bench rate is far above the analog limit; the port only counts edges
  parameter int HALF = 4
) (
  // clock
  input wire logic mclk,
  // link pins
  output logic select_shutdown_n,
  output logic sclk,
  output logic sdi,
  input wire logic sdo,
  input wire logic sdo_oe,
  // device status seen in each high phase
  input wire logic core_power,
  input wire logic sample_window,
  input wire logic hold
);
  logic host_en; // host drives the shared wire
  logic host_bit; // value launched by the host
  // undriven wire shows the inverse, so a stale value never passes
  assign sdi = sdo_oe ? sdo : (host_en ? host_bit : ~host_bit);
  // parked pins at time zero
  initial begin
    select_shutdown_n = 1'b1;
    sclk = 1'b0;
    host_en = 1'b1;
    host_bit = 1'b0;
  end
  // one frame: a leading zero, start, 3-bit word, then reads only
  task automatic frame(input logic [2:0] cfg, input int n, output logic [31:0] line, output logic [31:0] oe,
                       output logic [31:0] pwr, output logic [31:0] win, output logic [31:0] hld);
    logic [4:0] word;
    word = {2'b01, cfg};
    @(posedge mclk);
    select_shutdown_n <= 1'b0;
    repeat (HALF) @(posedge mclk);
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b0;
      host_en <= (i < 5);
      if (i < 5) begin
        host_bit <= word[4-i];
      end
      repeat (HALF) @(posedge mclk);
      sclk <= 1'b1;
      repeat (HALF / 2) @(posedge mclk);
      // sample mid high phase, well after the device launched
      line[i] = sdi;
      oe[i] = sdo_oe;
      pwr[i] = core_power;
      win[i] = sample_window;
      hld[i] = hold;
      repeat (HALF - HALF / 2) @(posedge mclk);
    end
    // stop the clock low, deselect, only then take the wire back
    sclk <= 1'b0;
    repeat (HALF) @(posedge mclk);
    select_shutdown_n <= 1'b1;
    repeat (HALF) @(posedge mclk);
    host_en <= 1'b1;
  endtask
  // chatter on clock and data while deselected
  task automatic noise(input int n);
    for (int i = 0; i < n; i++) begin
      sclk <= ~sclk;
      host_bit <= ~host_bit;
      repeat (HALF) @(posedge mclk);
    end
    sclk <= 1'b0;
    host_bit <= 1'b0;
    @(posedge mclk);
  endtask
endmodule // sadcp_host

/* dv/test_serial_adc_port_sequencer.sv */
// Purpose: self-checking bench for the serial adc port sequencer
// Assumes: shared data wire; comparator modelled from a target code
// Notes: result buffer is filled until it refuses, then drained with stalls
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin bad_count++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module test_serial_adc_port_sequencer;
  import sadcp_pkg::*;
  // one frame: word, analog code, shift clocks
  typedef struct packed {
    logic [2:0] cfg;
    logic [RES_W-1:0] code;
    logic [5:0] clocks;
  } sadcp_row_s;
  logic mclk = 1'b0; // system clock
  logic rst; // async reset
  logic select_shutdown_n, sclk, sdi, sdo, sdo_oe; // link pins
  logic core_power, sample_window, hold, input_mode_bit, chan_odd; // core control
  logic [RES_W-1:0] dac_code; // trial code
  logic comp_high = 1'b0; // comparator answer
  logic res_valid, res_ready; // result stream handshake
  logic [FIFO_W-1:0] res_data; // result word
  logic [RES_W-1:0] target; // analog input as an ideal code
  logic [31:0] d0, d1, d2, d3, d4; // captures of cut frames; only d1 is checked
  int bad_count;
  int check_count;
  logic [FIFO_W-1:0] exp_q[$]; // words the buffer owes us
  // every word mode, boundary codes, short frames when msb first
  sadcp_row_s rows [8] = '{'{3'h0, 12'h000, 6'd32}, '{3'h1, 12'hfff, 6'd32}, '{3'h2, 12'h800, 6'd32},
    '{3'h3, 12'h7ff, 6'd18}, '{3'h4, 12'h001, 6'd32}, '{3'h5, 12'hffe, 6'd32}, '{3'h6, 12'ha5a, 6'd32},
    '{3'h7, 12'h5a5, 6'd18}};

  always #4 mclk = ~mclk;

  sadcp_port #(.DEPTH(FIFO_DEPTH)) u_sadcp_port (.mclk(mclk), .rst(rst), .select_shutdown_n(select_shutdown_n),
    .sclk(sclk), .sdi(sdi), .sdo(sdo), .sdo_oe(sdo_oe), .core_power(core_power), .sample_window(sample_window),
    .hold(hold), .input_mode_bit(input_mode_bit), .chan_odd(chan_odd), .dac_code(dac_code), .comp_high(comp_high),
    .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));

  sadcp_host #(.HALF(4)) u_sadcp_host (.mclk(mclk), .select_shutdown_n(select_shutdown_n), .sclk(sclk), .sdi(sdi),
    .sdo(sdo), .sdo_oe(sdo_oe), .core_power(core_power), .sample_window(sample_window), .hold(hold));

  // ideal comparator: high while input is at or above the trial code
  always @(posedge mclk) comp_high <= (target >= dac_code);

  // line value at rise i: null, msb first, lsb copy from b1, zeros
  function automatic logic exp_bit(input int i, input logic [RES_W-1:0] r, input logic ord);
    if (i >= 6 && i <= 17) return r[17-i];
    if (i >= 18 && i <= 28 && !ord) return r[i-17];
    return 1'b0;
  endfunction

  // one frame through the host model, with its checks
  task automatic run_frame(input logic [2:0] cfg, input logic [RES_W-1:0] code, input int n, input logic take);
    logic [31:0] line, oe, pwr, win, hld;
    target <= code;
    u_sadcp_host.frame(cfg, n, line, oe, pwr, win, hld);
    @(posedge mclk);
    `CHK("deselected drive", 2'b00, {sdo_oe, core_power})
    if (take) begin
      exp_q.push_back({cfg[2:1], code});
      `CHK("mux steering", cfg[2:1], {input_mode_bit, chan_odd})
      `CHK("early drive", 7'h00, {oe[4:0], pwr[1:0]})
      `CHK("start seen", 1'b1, pwr[2])
      `CHK("turnaround", 2'b10, {oe[5], line[5]})
      `CHK("window", 4'b0110, win[5:2])
      `CHK("hold", 2'b10, hld[5:4])
      `CHK("auto power down", 3'b010, {pwr[17:16], hld[17]})
      for (int i = 5; i < n; i++) `CHK("serial bit", exp_bit(i, code, cfg[0]), line[i])
    end else begin
      // buffer full: start bit must be ignored
      `CHK("refused start", 16'h0000, {oe[7:0], pwr[7:0]})
    end
  endtask

  // drain the stream, stalling two cycles of every four
  task automatic drain();
    logic [FIFO_W-1:0] w;
    int guard;
    guard = 0;
    while (exp_q.size() > 0 && guard < 400) begin
      @(posedge mclk);
      if (res_valid === 1'b1 && res_ready === 1'b1) begin
        w = exp_q.pop_front();
        `CHK("result word", w, res_data)
      end
      res_ready <= guard[1] && (exp_q.size() > 0);
      guard++;
    end
    repeat (3) @(posedge mclk);
    `CHK("drained", 1'b0, res_valid)
    `CHK("words left", 0, exp_q.size())
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    res_ready = 1'b0;
    target = '0;
    bad_count = 0;
    check_count = 0;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    `CHK("after reset", 4'h0, {sdo_oe, core_power, hold, res_valid})
    $display("test reset done");
    foreach (rows[k]) run_frame(rows[k].cfg, rows[k].code, int'(rows[k].clocks), 1'b1);
    $display("test table done");
    u_sadcp_host.noise(12);
    `CHK("chatter ignored", 3'h0, {sdo_oe, core_power, sample_window})
    $display("test deselected done");
    for (int k = 8; k < FIFO_DEPTH; k++) run_frame(3'b111, 12'(k * 97), 18, 1'b1);
    run_frame(3'b001, 12'h123, 8, 1'b0);
    drain();
    $display("test full buffer done");
    // reset lands mid conversion; the aborted frame leaves no word
    fork
      u_sadcp_host.frame(3'b111, 10, d0, d1, d2, d3, d4);
      begin
        repeat (50) @(posedge mclk);
        rst <= 1'b1;
        @(posedge mclk);
        `CHK("reset outputs", 5'h00, {sdo_oe, core_power, hold, sample_window, res_valid})
        @(posedge mclk);
        rst <= 1'b0;
      end
    join
    // select rises mid conversion: port resets and keeps no word
    u_sadcp_host.frame(3'b011, 12, d0, d1, d2, d3, d4);
    @(posedge mclk);
    `CHK("cut frame", 2'b10, {d1[5], res_valid})
    run_frame(3'b010, 12'h3c3, 32, 1'b1);
    drain();
    $display("test mid-run reset done");
    close_out();
  end

  // watchdog, well past the expected run of about 6400 cycles
  initial begin
    repeat (40000) @(posedge mclk);
    bad_count++;
    $display("watchdog expired");
    close_out();
  end
endmodule // test_serial_adc_port_sequencer
